// [hdl/dbc_ctrl.sv]
`timescale 1ns/1ps
// How it works
// RQ1 - compare cpu address bus against 16-bit break match register
// RQ2 - forced mode: any access at match halts at next instruction boundary
// RQ3 - tagged mode: fetched opcode marked, halt when it reaches queue end
// RQ4 - break enable low after reset blocks all breakpoints, ignores select and match
// RQ5 - force/tag select 1 chooses forced, 0 chooses tagged
// RQ6 - debug registers reached only by serial commands, never by user program
// RQ7 - writes to background permit ignored while background mode active
// RQ8 - active, wait/stop, failure bits read-only, control write never alters them
// RQ9 - clock select defaults 0 alternate clock, 1 bus clock, always writable; a control write in the strap reset cycle is overridden
// RQ10 - normal reset clears all; background reset sets permit, active, clock select
// RQ11 - permit 0 blocks background entry; once set stays until normal reset
// RQ12 - active bit reads 1 in background mode, 0 while program runs
// RQ13 - wait/stop flag shows wait/stop, or background entered from it
// RQ14 - background command pulls cpu out of wait/stop into background
// RQ15 - wait/stop failure set when memory command collides with wait/stop
// RQ16 - data valid failure always reads 0, no slow memory here
// RQ17 - host checks active bit after forcing background mode
// RQ18 - host recovers from wait/stop failure via background, retry, resume
// RQ19 - break match register 16 bits, accessed by break read/write commands
// RQ20 - host normally sets breakpoints while in background mode
// RQ21 - force-reset register ignores user writes and reads 0x00
// RQ22 - serial write of 1 to force-reset bit 0 forces mcu reset
// RQ23 - status read E4 and control write C4 carry eight bits
// RQ24 - break read E2 and break write C2 carry sixteen bits
// RQ25 - break match register clears to zero on reset
module dbc_ctrl
  import dbc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic bkgd_strap_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_access,
  input wire logic cpu_write,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_fetch,
  input wire logic cpu_boundary,
  input wire logic cpu_tag_end,
  input wire logic cpu_wait_stop,
  input wire logic mem_wait_fail,
  output logic tag_mark,
  output logic bkgd_active,
  output logic comm_clock_select,
  output logic force_reset
);
  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  logic strap_s1_q, strap_s2_q;
  logic [1:0] settle_q, settle_d;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_s1_q <= 1'b1;
      strap_s2_q <= 1'b1;
    end else begin
      strap_s1_q <= bkgd_strap_n;
      strap_s2_q <= strap_s1_q;
    end
  end
  always_comb begin
    settle_d = settle_q;
    if (settle_q != STRAP_SETTLE) begin
      settle_d = settle_q + 2'h1;
    end
  end
  // strap is trusted only once the synchroniser has filled
  logic strap_take;
  assign strap_take = (settle_q == STRAP_SETTLE - 2'h1);

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic c_bg, c_rds, c_wrc, c_rdb, c_wrb, c_go, c_rdbyte, c_wrbyte;
  // RQ6 serial-only access
  assign c_bg = cmd_valid && cmd_code == CMD_BACKGROUND;
  assign c_rds = cmd_valid && cmd_code == CMD_RD_STATUS;
  assign c_wrc = cmd_valid && cmd_code == CMD_WR_CONTROL;
  assign c_rdb = cmd_valid && cmd_code == CMD_RD_BREAK;
  assign c_wrb = cmd_valid && cmd_code == CMD_WR_BREAK;
  assign c_go = cmd_valid && (cmd_code == CMD_GO || cmd_code == CMD_TRACE1
                || cmd_code == CMD_TAGGO);
  assign c_rdbyte = cmd_valid && cmd_code == CMD_RD_BYTE && cmd_addr == FRC_RST_ADDR;
  assign c_wrbyte = cmd_valid && cmd_code == CMD_WR_BYTE && cmd_addr == FRC_RST_ADDR;

  // ----------------------------------------------------------------
  // status/control and breakpoint state
  // ----------------------------------------------------------------
  dbc_mode_t mode_q, mode_d;
  logic permit_q, permit_d, brk_en_q, brk_en_d, ftag_q, ftag_d, clk_sel_q, clk_sel_d;
  logic wait_bg_q, wait_bg_d, wait_fail_q, wait_fail_d, force_pend_q, force_pend_d;
  logic [15:0] brk_q, brk_d;
  logic match, brk_hit, enter, active;
  logic [7:0] status;

  assign active = (mode_q == DBC_HALT);
  // RQ1 address compare
  assign match = cpu_addr == brk_q;
  // RQ4 disabled breakpoint
  assign brk_hit = brk_en_q && cpu_access && match;
  // RQ11 permit gates entry
  // RQ2 forced entry on boundary
  // RQ3 tagged entry at queue end
  // RQ14 background command
  // RQ5 force/tag select
  assign enter = permit_q && !active && (c_bg || (cpu_boundary && (force_pend_q ||
                 (brk_hit && ftag_q))) || (cpu_tag_end && brk_en_q && !ftag_q));
  // RQ12 active bit
  // RQ13 wait/stop flag
  // RQ16 data valid failure
  always_comb begin
    status = 8'h00;
    status[BIT_PERMIT] = permit_q;
    status[BIT_ACTIVE] = active;
    status[BIT_BRK_EN] = brk_en_q;
    status[BIT_FTAG] = ftag_q;
    status[BIT_CLK_SEL] = clk_sel_q;
    status[BIT_WAIT] = cpu_wait_stop || wait_bg_q;
    status[BIT_WAIT_FAIL] = wait_fail_q;
    status[BIT_DATA_FAIL] = 1'b0;
  end

  always_comb begin
    mode_d = mode_q;
    permit_d = permit_q;
    brk_en_d = brk_en_q;
    ftag_d = ftag_q;
    clk_sel_d = clk_sel_q;
    wait_bg_d = wait_bg_q;
    wait_fail_d = wait_fail_q;
    brk_d = brk_q;
    force_pend_d = force_pend_q;
    // RQ2 remember forced hit until boundary
    if (brk_hit && ftag_q && !cpu_boundary && !active) begin
      force_pend_d = 1'b1;
    end
    if (enter || !brk_en_q || !ftag_q) begin
      force_pend_d = 1'b0;
    end
    if (enter) begin
      mode_d = DBC_HALT;
      wait_bg_d = c_bg && cpu_wait_stop;
    end else if (c_go && active) begin
      mode_d = DBC_RUN;
      wait_bg_d = 1'b0;
    end
    // RQ15 failure flag, clear by background command, set wins
    if (c_bg) begin
      wait_fail_d = 1'b0;
    end
    if (mem_wait_fail) begin
      wait_fail_d = 1'b1;
    end
    // RQ8 only control bits written
    // RQ9 clock select writable except in the strap reset cycle
    // RQ7 permit frozen while active
    if (c_wrc) begin
      brk_en_d = cmd_wdata[BIT_BRK_EN];
      ftag_d = cmd_wdata[BIT_FTAG];
      clk_sel_d = cmd_wdata[BIT_CLK_SEL];
      if (!active) begin
        permit_d = permit_q || cmd_wdata[BIT_PERMIT];
      end
    end
    // RQ19 break register write
    if (c_wrb) begin
      brk_d = cmd_wdata;
    end
    // RQ10 reset into background mode
    // early control, go and background commands are overridden so the strap state matches a clean reset
    if (strap_take && !strap_s2_q) begin
      mode_d = DBC_HALT;
      brk_en_d = 1'b0;
      ftag_d = 1'b0;
      wait_bg_d = 1'b0;
      wait_fail_d = 1'b0;
      permit_d = 1'b1;
      clk_sel_d = 1'b1;
    end
  end

  logic rsp_valid_d, tag_d, frc_d;
  logic [15:0] rsp_d;
  always_comb begin
    rsp_valid_d = c_rds || c_rdb || c_rdbyte;
    rsp_d = 16'h0000;
    // RQ23 eight-bit status answer
    // RQ24 sixteen-bit break answer
    // RQ21 force-reset reads zero
    if (c_rds) begin
      rsp_d = {8'h00, status};
    end else if (c_rdb) begin
      rsp_d = brk_q;
    end else if (c_rdbyte) begin
      rsp_d = {8'h00, FRC_RST_READ};
    end
    // RQ3 mark tagged opcode
    tag_d = brk_en_q && !ftag_q && cpu_fetch && match;
    // RQ22 serial force reset
    frc_d = c_wrbyte && cmd_wdata[BIT_FRC_RST];
  end

  // RQ10 normal reset clears all
  // RQ25 break register reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      settle_q <= 2'h0;
      mode_q <= DBC_RUN;
      permit_q <= 1'b0;
      brk_en_q <= 1'b0;
      ftag_q <= 1'b0;
      clk_sel_q <= 1'b0;
      wait_bg_q <= 1'b0;
      wait_fail_q <= 1'b0;
      force_pend_q <= 1'b0;
      brk_q <= BREAK_RESET;
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
      tag_mark <= 1'b0;
      bkgd_active <= 1'b0;
      comm_clock_select <= 1'b0;
      force_reset <= 1'b0;
    end else begin
      settle_q <= settle_d;
      mode_q <= mode_d;
      permit_q <= permit_d;
      brk_en_q <= brk_en_d;
      ftag_q <= ftag_d;
      clk_sel_q <= clk_sel_d;
      wait_bg_q <= wait_bg_d;
      wait_fail_q <= wait_fail_d;
      force_pend_q <= force_pend_d;
      brk_q <= brk_d;
      rsp_valid <= rsp_valid_d;
      rsp_data <= rsp_d;
      tag_mark <= tag_d;
      bkgd_active <= (mode_d == DBC_HALT);
      comm_clock_select <= clk_sel_d;
      force_reset <= frc_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // user writes to the force-reset address are deliberately unused
  logic user_wr_ignored;
  assign user_wr_ignored = cpu_access && cpu_write && cpu_addr == FRC_RST_ADDR
                           && cpu_wdata[BIT_FRC_RST];

  no_brk_off_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RQ4
    !brk_en_q |=> !tag_mark)
    else $error("tag mark while breakpoint disabled");
  permit_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RQ11
    permit_q |=> permit_q)
    else $error("permit bit dropped");
  permit_frz_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RQ7
    (active && c_wrc && !strap_take) |=> permit_q == $past(permit_q))
    else $error("permit changed in background");
  no_entry_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RQ11
    (!permit_q && !active && !strap_take) |=> !active)
    else $error("background entered without permit");
  bg_cmd_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RQ14
    (c_bg && permit_q) |=> bkgd_active)
    else $error("background command not honoured");
  brk_rd_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RQ19
    (c_wrb ##1 !c_wrb ##1 c_rdb) |=> (rsp_valid && rsp_data == $past(cmd_wdata, 3)))
    else $error("break register readback wrong");
  force_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RQ2
    (brk_en_q && ftag_q && permit_q && !active && brk_hit && cpu_boundary)
    |=> bkgd_active)
    else $error("forced breakpoint missed");
  frc_user_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RQ21
    (user_wr_ignored && !c_wrbyte) |=> !force_reset)
    else $error("user write forced reset");
  frc_cmd_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RQ22
    c_wrbyte && cmd_wdata[0] |=> force_reset)
    else $error("force reset not raised");
  clk_sel_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RQ9
    (c_wrc && !strap_take) |=> comm_clock_select == $past(cmd_wdata[BIT_CLK_SEL]))
    else $error("clock select not written");
  data_fail_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RQ16
    (rsp_valid && $past(c_rds)) |-> !rsp_data[BIT_DATA_FAIL])
    else $error("data valid failure set");
endmodule : dbc_ctrl

// [hdl/dbc_pkg.sv]
package dbc_pkg;
  // serial command codes
  localparam logic [7:0] CMD_BACKGROUND = 8'h90;
  localparam logic [7:0] CMD_RD_STATUS = 8'he4;
  localparam logic [7:0] CMD_WR_CONTROL = 8'hc4;
  localparam logic [7:0] CMD_RD_BREAK = 8'he2;
  localparam logic [7:0] CMD_WR_BREAK = 8'hc2;
  localparam logic [7:0] CMD_RD_BYTE = 8'he0;
  localparam logic [7:0] CMD_WR_BYTE = 8'hc0;
  localparam logic [7:0] CMD_GO = 8'h08;
  localparam logic [7:0] CMD_TRACE1 = 8'h10;
  localparam logic [7:0] CMD_TAGGO = 8'h18;
  // status/control and force-reset bit positions
  localparam int BIT_PERMIT = 7;
  localparam int BIT_ACTIVE = 6;
  localparam int BIT_BRK_EN = 5;
  localparam int BIT_FTAG = 4;
  localparam int BIT_CLK_SEL = 3;
  localparam int BIT_WAIT = 2;
  localparam int BIT_WAIT_FAIL = 1;
  localparam int BIT_DATA_FAIL = 0;
  localparam int BIT_FRC_RST = 0;
  // memory address of the force-reset register
  localparam logic [15:0] FRC_RST_ADDR = 16'h0000;
  localparam logic [7:0] FRC_RST_READ = 8'h00;
  localparam logic [15:0] BREAK_RESET = 16'h0000;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  typedef enum logic [1:0] {
    DBC_RUN = 2'b00,
    DBC_HALT = 2'b01
  } dbc_mode_t;
endpackage : dbc_pkg

// [testbench/dbc_ctrl_tb.sv]
`timescale 1ns/1ps
module dbc_ctrl_tb;
  import dbc_pkg::*;
  // ----------------
  // signals and parts
  // ----------------
  logic sys_clk, reset_n, bkgd_strap_n, cmd_valid, rsp_valid, got;
  logic [7:0] cmd_code, cpu_wdata;
  logic [15:0] cmd_addr, cmd_wdata, rsp_data, cpu_addr, rd;
  logic cpu_access, cpu_write, cpu_fetch, cpu_boundary, cpu_tag_end, cpu_wait_stop, mem_wait_fail;
  logic tag_mark, bkgd_active, comm_clock_select, force_reset;
  int n_fail, checks;
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  dbc_ctrl i_dbc_ctrl (.sys_clk(sys_clk), .reset_n(reset_n), .bkgd_strap_n(bkgd_strap_n),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .cpu_addr(cpu_addr), .cpu_access(cpu_access),
    .cpu_write(cpu_write), .cpu_wdata(cpu_wdata), .cpu_fetch(cpu_fetch),
    .cpu_boundary(cpu_boundary), .cpu_tag_end(cpu_tag_end), .cpu_wait_stop(cpu_wait_stop),
    .mem_wait_fail(mem_wait_fail), .tag_mark(tag_mark), .bkgd_active(bkgd_active),
    .comm_clock_select(comm_clock_select), .force_reset(force_reset));
  dbc_host i_dbc_host (.sys_clk(sys_clk), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata));
  // ----------------
  // tasks
  // ----------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] c, input logic [15:0] w);
    i_dbc_host.send(c, FRC_RST_ADDR, w, got, rd);
  endtask : cmd
  task automatic status(input logic [7:0] exp);
    cmd(CMD_RD_STATUS, 16'h0000);
    chk("status answer", 16'(got), 16'h0001);
    chk("status", rd, {8'h00, exp});
  endtask : status
  // flags: access, write, fetch, boundary, tag end
  task automatic cpu(input logic [4:0] f, input logic [15:0] a);
    @(posedge sys_clk);
    {cpu_access, cpu_write, cpu_fetch, cpu_boundary, cpu_tag_end} <= f;
    cpu_addr <= a;
    #1;
  endtask : cpu
  task automatic note(input string t);
    $display("test %s finished", t);
  endtask : note
  task automatic final_report;
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  // ----------------
  // tests
  // ----------------
  initial begin
    #20000;
    n_fail++;
    final_report;
  end
  initial begin
    reset_n = 1'b0;
    bkgd_strap_n = 1'b1;
    {cpu_access, cpu_write, cpu_fetch, cpu_boundary, cpu_tag_end} = 5'h00;
    cpu_addr = 16'h0000;
    cpu_wdata = 8'h01;
    cpu_wait_stop = 1'b0;
    mem_wait_fail = 1'b0;
    n_fail = 0;
    checks = 0;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    status(8'h00);
    cmd(CMD_RD_BREAK, 16'h0000);
    chk("break after reset", rd, BREAK_RESET);
    chk("clock select", 16'(comm_clock_select), 16'h0000);
    note("reset");
    cmd(CMD_WR_CONTROL, 16'h00ff);
    status(8'hb8);
    chk("clock select", 16'(comm_clock_select), 16'h0001);
    cmd(CMD_WR_CONTROL, 16'h0000);
    status(8'h80);
    cmd(CMD_WR_BREAK, 16'h1234);
    cmd(CMD_RD_BREAK, 16'h0000);
    chk("break", rd, 16'h1234);
    note("registers");
    // breakpoint armed while halted, then the program resumes
    cmd(CMD_BACKGROUND, 16'h0000);
    status(8'hc0);
    cmd(CMD_WR_CONTROL, 16'h00b0);
    cmd(CMD_GO, 16'h0000);
    chk("active after go", 16'(bkgd_active), 16'h0000);
    cpu(5'h12, 16'h1235);
    cpu(5'h00, 16'h0000);
    chk("active on other address", 16'(bkgd_active), 16'h0000);
    cpu(5'h10, 16'h1234);
    cpu(5'h02, 16'h0000);
    chk("active before boundary", 16'(bkgd_active), 16'h0000);
    cpu(5'h00, 16'h0000);
    chk("active at boundary", 16'(bkgd_active), 16'h0001);
    status(8'hf0);
    cmd(CMD_WR_CONTROL, 16'h0030);
    status(8'hf0);
    cmd(CMD_GO, 16'h0000);
    status(8'hb0);
    cpu(5'h12, 16'h1234);
    cpu(5'h00, 16'h0000);
    chk("active on access at boundary", 16'(bkgd_active), 16'h0001);
    cmd(CMD_TRACE1, 16'h0000);
    chk("active after trace", 16'(bkgd_active), 16'h0000);
    note("forced");
    cmd(CMD_WR_CONTROL, 16'h00a0);
    cpu(5'h04, 16'h1234);
    cpu(5'h00, 16'h0000);
    chk("tag mark", 16'(tag_mark), 16'h0001);
    cpu(5'h01, 16'h0000);
    cpu(5'h00, 16'h0000);
    chk("active by tag", 16'(bkgd_active), 16'h0001);
    cmd(CMD_TAGGO, 16'h0000);
    chk("active after tag go", 16'(bkgd_active), 16'h0000);
    cmd(CMD_WR_CONTROL, 16'h0080);
    cpu(5'h04, 16'h1234);
    cpu(5'h01, 16'h0000);
    chk("tag mark off", 16'(tag_mark), 16'h0000);
    cpu(5'h00, 16'h0000);
    chk("active tag off", 16'(bkgd_active), 16'h0000);
    cmd(CMD_WR_CONTROL, 16'h0090);
    cpu(5'h16, 16'h1234);
    cpu(5'h01, 16'h0000);
    chk("tag mark disabled", 16'(tag_mark), 16'h0000);
    cpu(5'h00, 16'h0000);
    chk("active disabled", 16'(bkgd_active), 16'h0000);
    note("tagged and disabled");
    @(posedge sys_clk);
    cpu_wait_stop <= 1'b1;
    mem_wait_fail <= 1'b1;
    @(posedge sys_clk);
    mem_wait_fail <= 1'b0;
    status(8'h96);
    cmd(CMD_BACKGROUND, 16'h0000);
    chk("active by command", 16'(bkgd_active), 16'h0001);
    @(posedge sys_clk);
    cpu_wait_stop <= 1'b0;
    status(8'hd4);
    cmd(CMD_GO, 16'h0000);
    status(8'h90);
    note("wait stop");
    cpu(5'h18, FRC_RST_ADDR);
    cpu(5'h00, 16'h0000);
    chk("user force reset", 16'(force_reset), 16'h0000);
    cmd(CMD_WR_BYTE, 16'h0001);
    chk("serial force reset", 16'(force_reset), 16'h0001);
    cmd(CMD_RD_BYTE, 16'h0000);
    chk("force reset read", rd, {8'h00, FRC_RST_READ});
    cmd(8'h55, 16'h0000);
    chk("unknown code answer", 16'(got), 16'h0000);
    note("force reset");
    @(posedge sys_clk);
    reset_n <= 1'b0;
    bkgd_strap_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    status(8'hc8);
    chk("strap active", 16'(bkgd_active), 16'h0001);
    chk("strap clock select", 16'(comm_clock_select), 16'h0001);
    cmd(CMD_RD_BREAK, 16'h0000);
    chk("break after reset", rd, BREAK_RESET);
    note("strap reset");
    final_report;
  end
endmodule : dbc_ctrl_tb

// [testbench/dbc_host.sv]
`timescale 1ns/1ps
module dbc_host (
  input wire logic sys_clk,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_addr,
  output logic [15:0] cmd_wdata
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    cmd_addr = 16'h0000;
    cmd_wdata = 16'h0000;
  end
  task automatic send(input logic [7:0] c, input logic [15:0] a, input logic [15:0] w,
                      output logic ok, output logic [15:0] d);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_addr <= a;
    cmd_wdata <= w;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    // released lines carry the inverse so a stale value never passes
    cmd_code <= ~c;
    cmd_addr <= ~a;
    cmd_wdata <= ~w;
    #1;
    ok = rsp_valid;
    d = rsp_data;
  endtask : send
endmodule : dbc_host
